// File: include/ccr_map.svh
// register offsets, field positions and reset values for the codec control subset
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH

// register numbers carried in the pointer byte
`define CCR_REG3 8'h03
`define CCR_REG4 8'h04
`define CCR_REG5 8'h05

// sub-register select codes in D7-D6
`define CCR_SUB_HI 7
`define CCR_SUB_LO 6
`define CCR_SUB_A 2'h0
`define CCR_SUB_B 2'h1
`define CCR_SUB_C 2'h2
`define CCR_SUB_D 2'h3

// output mute and filter bits
`define CCR_BIT_FILT 5
`define CCR_BIT_HNS 3
`define CCR_BIT_HDS 2
`define CCR_BIT_LNO 1
`define CCR_BIT_SPK 0

// version and oversampling fields
`define CCR_VER_HI 4
`define CCR_VER_LO 2
`define CCR_OSR_HI 1
`define CCR_OSR_LO 0
`define CCR_OSR_RST 2'h0
`define CCR_OSR_512 10'h200
`define CCR_OSR_256 10'h100
`define CCR_OSR_128 10'h080
`define CCR_OSR_CODE_256 2'h2

// six-bit fields: bias value and adc gain
`define CCR_SIX_HI 5
`define CCR_SIX_LO 0
`define CCR_SIX_RST 6'h00

// divider register fields
`define CCR_DIV_SEL 7
`define CCR_M_HI 6
`define CCR_M_LO 0
`define CCR_N_HI 6
`define CCR_N_LO 3
`define CCR_P_HI 2
`define CCR_P_LO 0
`define CCR_M_RST 7'h01
`define CCR_N_RST 4'h1
`define CCR_P_RST 3'h1
`define CCR_M_ZERO_VAL 8'h80
`define CCR_N_ZERO_VAL 5'h10
`define CCR_P_ZERO_VAL 4'h8
`define CCR_FS_PRESCALE 21'h000010

// adc gain codes, gain in half-dB units
`define CCR_GAIN_LIN_MAX 6'h1B
`define CCR_GAIN_C28 6'h1C
`define CCR_GAIN_C29 6'h1D
`define CCR_GAIN_C30 6'h1E
`define CCR_GAIN_MUTE 6'h1F
`define CCR_GAIN_42DB 7'h54
`define CCR_GAIN_48DB 7'h60
`define CCR_GAIN_54DB 7'h6C
`define CCR_GAIN_STEP 7'h03

// two-wire port
`define CCR_BITS_PER_BYTE 4'h8

`endif

// File: include/ccr_pkg.sv
// types for the codec control subset
package ccr_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_REG,
    ST_WDATA,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } ccr_state_t;

  typedef struct packed {
    logic voiceFilter;
    logic handsetMute;
    logic headsetMute;
    logic lineOutMute;
    logic speakerMute;
  } ccr_drv_t;

  typedef struct packed {
    logic [6:0] mCode;
    logic [3:0] nCode;
    logic [2:0] pCode;
  } ccr_div_t;

endpackage

// File: design/ccr_fs_divider.sv
// frame-sync divider: one pulse every 16*M*N*P master clocks
`timescale 1ns/1ps
`include "ccr_map.svh"

module ccr_fs_divider #(
  parameter int CNT_W = 21
) (
  input wire logic clk,
  input wire logic rst,
  input wire ccr_pkg::ccr_div_t divCode,
  output logic frameSyncQ
);

  if (CNT_W < 19 || CNT_W > 21) begin : g_bad_width
    $error("ccr_fs_divider: CNT_W must be 19 to 21");
  end

  logic [7:0] mVal;
  logic [4:0] nVal;
  logic [3:0] pVal;
  logic [CNT_W-1:0] product;
  logic [CNT_W-1:0] terminal;
  logic [CNT_W-1:0] cnt_q;

  // zero codes stand for the top of each range
  always_comb begin
    mVal = (divCode.mCode == 7'h00) ? `CCR_M_ZERO_VAL : {1'b0, divCode.mCode}; // R10
    nVal = (divCode.nCode == 4'h0) ? `CCR_N_ZERO_VAL : {1'b0, divCode.nCode}; // R12 R16
    pVal = (divCode.pCode == 3'h0) ? `CCR_P_ZERO_VAL : {1'b0, divCode.pCode}; // R11
    product = CNT_W'(mVal) * CNT_W'(nVal) * CNT_W'(pVal) * CNT_W'(`CCR_FS_PRESCALE); // R9
    terminal = product - CNT_W'(1'b1);
  end

  // count master clocks, wrap early if the divider shrinks
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      frameSyncQ <= 1'b0;
    end else if (cnt_q >= terminal) begin
      cnt_q <= '0;
      frameSyncQ <= 1'b1; // R9
    end else begin
      cnt_q <= cnt_q + CNT_W'(1'b1);
      frameSyncQ <= 1'b0;
    end
  end

endmodule

// File: design/ccr_regs.sv
// codec control register subset behind a two-wire host port
// Summary of operation
// R1: D5 enables 300 Hz-3.3 kHz voice filter
// R2: D3 mutes handset, D2 mutes headset
// R3: D1 mutes the line output driver
// R4: D0 mutes the speaker driver
// R5: D4-D2 reads device version code
// R6: D1-D0 picks DAC oversampling 512/256/128
// R7: D5-D0 holds bias DAC input value
// R8: D7 chooses M load or N,P load
// R9: frame sync is clock over 16*M*N*P
// R10: M field zero means 128
// R11: P field zero means 8
// R12: N field codes 1-15 give N
// R13: gain code steps 1.5 dB to 27
// R14: codes 28-30 give 42/48/54 dB, 31 mutes
// R15: host selects sub-register in D7-D6
// R16: N field zero means 16
`timescale 1ns/1ps
`include "ccr_map.svh"

module ccr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h40,
  // arbitrary version code
  parameter logic [2:0] VERSION_CODE = 3'h5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOutQ,
  output logic sdaOeQ,
  output ccr_pkg::ccr_drv_t driverCtrlQ,
  output logic [1:0] osrSelectQ,
  output logic [9:0] osrRatioQ,
  output logic [5:0] biasDacQ,
  output ccr_pkg::ccr_div_t divCodeQ,
  output logic frameSyncQ,
  output logic [5:0] adcGainCodeQ,
  output logic [6:0] adcGainHalfDbQ,
  output logic adcInputMuteQ
);

  if (DEV_ADDR == 7'h00) begin : g_bad_addr
    $error("ccr_regs: DEV_ADDR must not be the general call address");
  end

  // pin synchronisers: index 0 is scl, index 1 is sda
  logic [1:0] pinIn;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] sync3_q;
  logic [1:0] stable_q;
  logic [1:0] prev_q;

  assign pinIn = {sdaIn, scl};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
          sync3_q[gi] <= 1'b1;
          stable_q[gi] <= 1'b1;
          prev_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pinIn[gi];
          sync2_q[gi] <= sync1_q[gi];
          sync3_q[gi] <= sync2_q[gi];
          if (sync2_q[gi] == sync3_q[gi]) begin
            stable_q[gi] <= sync3_q[gi];
          end
          prev_q[gi] <= stable_q[gi];
        end
      end
    end
  endgenerate

  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startEv;
  logic stopEv;

  always_comb begin
    sclS = stable_q[0];
    sdaS = stable_q[1];
    sclRise = sclS && !prev_q[0];
    sclFall = !sclS && prev_q[0];
    startEv = sclS && prev_q[0] && !sdaS && prev_q[1];
    stopEv = sclS && prev_q[0] && sdaS && !prev_q[1];
  end

  // pointer decode shared by write and read paths
  function automatic logic ptrIs(input logic [7:0] ptr, input logic [7:0] reg_num);
    ptrIs = (ptr == reg_num);
  endfunction

  // stored register state
  logic [7:0] regPtr_q;
  logic [1:0] rdSub3_q;
  logic [7:0] div4Last_q;
  logic [7:0] readByte;

  always_comb begin
    readByte = 8'h00;
    if (ptrIs(regPtr_q, `CCR_REG3)) begin
      if (rdSub3_q == `CCR_SUB_B) begin
        readByte = {`CCR_SUB_B, driverCtrlQ.voiceFilter, 1'b0, driverCtrlQ.handsetMute,
                    driverCtrlQ.headsetMute, driverCtrlQ.lineOutMute, driverCtrlQ.speakerMute};
      end else if (rdSub3_q == `CCR_SUB_C) begin
        readByte = {`CCR_SUB_C, 1'b0, VERSION_CODE, osrSelectQ}; // R5
      end else if (rdSub3_q == `CCR_SUB_D) begin
        readByte = {`CCR_SUB_D, biasDacQ};
      end
    end else if (ptrIs(regPtr_q, `CCR_REG4)) begin
      readByte = div4Last_q;
    end else if (ptrIs(regPtr_q, `CCR_REG5)) begin
      readByte = {`CCR_SUB_A, adcGainCodeQ};
    end
  end

  // two-wire slave receiver and transmitter
  ccr_pkg::ccr_state_t state_q;
  ccr_pkg::ccr_state_t afterAck_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [7:0] txShift_q;
  logic nack_q;
  logic wrStb_q;
  logic [7:0] wrData_q;
  logic [7:0] rxByte;

  assign rxByte = shift_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ccr_pkg::ST_IDLE;
      afterAck_q <= ccr_pkg::ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      txShift_q <= 8'h00;
      nack_q <= 1'b0;
      sdaOeQ <= 1'b0;
      regPtr_q <= 8'h00;
      wrStb_q <= 1'b0;
      wrData_q <= 8'h00;
    end else begin
      wrStb_q <= 1'b0;
      if (startEv) begin
        state_q <= ccr_pkg::ST_ADDR;
        bitCnt_q <= 4'h0;
        sdaOeQ <= 1'b0;
      end else if (stopEv) begin
        state_q <= ccr_pkg::ST_IDLE;
        sdaOeQ <= 1'b0;
      end else begin
        case (state_q)
          ccr_pkg::ST_ADDR, ccr_pkg::ST_REG, ccr_pkg::ST_WDATA: begin
            if (sclRise) begin
              shift_q <= {shift_q[6:0], sdaS};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall && bitCnt_q == `CCR_BITS_PER_BYTE) begin
              bitCnt_q <= 4'h0;
              if (state_q == ccr_pkg::ST_ADDR) begin
                if (rxByte[7:1] == DEV_ADDR) begin
                  state_q <= ccr_pkg::ST_ACK;
                  sdaOeQ <= 1'b1;
                  if (rxByte[0]) begin
                    afterAck_q <= ccr_pkg::ST_TX;
                    txShift_q <= readByte;
                  end else begin
                    afterAck_q <= ccr_pkg::ST_REG;
                  end
                end else begin
                  state_q <= ccr_pkg::ST_IDLE;
                end
              end else if (state_q == ccr_pkg::ST_REG) begin
                regPtr_q <= rxByte;
                state_q <= ccr_pkg::ST_ACK;
                sdaOeQ <= 1'b1;
                afterAck_q <= ccr_pkg::ST_WDATA;
              end else begin
                wrData_q <= rxByte;
                wrStb_q <= 1'b1;
                state_q <= ccr_pkg::ST_ACK;
                sdaOeQ <= 1'b1;
                afterAck_q <= ccr_pkg::ST_WDATA;
              end
            end
          end
          ccr_pkg::ST_ACK: begin
            if (sclFall) begin
              state_q <= afterAck_q;
              bitCnt_q <= 4'h0;
              sdaOeQ <= (afterAck_q == ccr_pkg::ST_TX) ? !txShift_q[7] : 1'b0;
            end
          end
          ccr_pkg::ST_TX: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (sclFall) begin
              if (bitCnt_q == `CCR_BITS_PER_BYTE) begin
                state_q <= ccr_pkg::ST_TXACK;
                bitCnt_q <= 4'h0;
                sdaOeQ <= 1'b0;
              end else begin
                txShift_q <= {txShift_q[6:0], 1'b0};
                sdaOeQ <= !txShift_q[6];
              end
            end
          end
          ccr_pkg::ST_TXACK: begin
            if (sclRise) begin
              nack_q <= sdaS;
              txShift_q <= readByte;
            end else if (sclFall) begin
              if (nack_q) begin
                state_q <= ccr_pkg::ST_IDLE;
                sdaOeQ <= 1'b0;
              end else begin
                state_q <= ccr_pkg::ST_TX;
                sdaOeQ <= !txShift_q[7];
              end
            end
          end
          default: begin
            state_q <= ccr_pkg::ST_IDLE;
            sdaOeQ <= 1'b0;
          end
        endcase
      end
    end
  end

  // open-drain: only ever pulls low
  always_ff @(posedge clk) begin
    sdaOutQ <= 1'b0;
  end

  logic [1:0] wrSub;
  logic wr3;
  logic wr4;
  logic wr5;

  always_comb begin
    wrSub = wrData_q[`CCR_SUB_HI:`CCR_SUB_LO]; // R15
    wr3 = wrStb_q && ptrIs(regPtr_q, `CCR_REG3);
    wr4 = wrStb_q && ptrIs(regPtr_q, `CCR_REG4);
    wr5 = wrStb_q && ptrIs(regPtr_q, `CCR_REG5) && (wrSub == `CCR_SUB_A);
  end

  // read-back sub-register follows the last register 3 write with sub-register B, C or D
  always_ff @(posedge clk) begin
    if (rst) begin
      rdSub3_q <= `CCR_SUB_B;
    end else if (wr3 && wrSub != `CCR_SUB_A) begin
      rdSub3_q <= wrSub;
    end
  end

  // output drivers and voice filter
  always_ff @(posedge clk) begin
    if (rst) begin
      driverCtrlQ <= '0; // R1 R2 R3 R4
    end else if (wr3 && wrSub == `CCR_SUB_B) begin
      driverCtrlQ.voiceFilter <= wrData_q[`CCR_BIT_FILT]; // R1
      driverCtrlQ.handsetMute <= wrData_q[`CCR_BIT_HNS]; // R2
      driverCtrlQ.headsetMute <= wrData_q[`CCR_BIT_HDS]; // R2
      driverCtrlQ.lineOutMute <= wrData_q[`CCR_BIT_LNO]; // R3
      driverCtrlQ.speakerMute <= wrData_q[`CCR_BIT_SPK]; // R4
    end
  end

  // dac oversampling select and ratio
  always_ff @(posedge clk) begin
    if (rst) begin
      osrSelectQ <= `CCR_OSR_RST;
    end else if (wr3 && wrSub == `CCR_SUB_C) begin
      osrSelectQ <= wrData_q[`CCR_OSR_HI:`CCR_OSR_LO]; // R6
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      osrRatioQ <= `CCR_OSR_128;
    end else if (osrSelectQ[0]) begin
      osrRatioQ <= `CCR_OSR_512; // R6
    end else if (osrSelectQ == `CCR_OSR_CODE_256) begin
      osrRatioQ <= `CCR_OSR_256; // R6
    end else begin
      osrRatioQ <= `CCR_OSR_128; // R6
    end
  end

  // bias dac input value
  always_ff @(posedge clk) begin
    if (rst) begin
      biasDacQ <= `CCR_SIX_RST; // R7
    end else if (wr3 && wrSub == `CCR_SUB_D) begin
      biasDacQ <= wrData_q[`CCR_SIX_HI:`CCR_SIX_LO]; // R7
    end
  end

  // divider fields, loaded by the select bit
  always_ff @(posedge clk) begin
    if (rst) begin
      divCodeQ.mCode <= `CCR_M_RST;
      divCodeQ.nCode <= `CCR_N_RST;
      divCodeQ.pCode <= `CCR_P_RST;
      div4Last_q <= 8'h00;
    end else if (wr4) begin
      div4Last_q <= wrData_q;
      if (wrData_q[`CCR_DIV_SEL]) begin
        divCodeQ.mCode <= wrData_q[`CCR_M_HI:`CCR_M_LO]; // R8
      end else begin
        divCodeQ.nCode <= wrData_q[`CCR_N_HI:`CCR_N_LO]; // R8
        divCodeQ.pCode <= wrData_q[`CCR_P_HI:`CCR_P_LO]; // R8
      end
    end
  end

  ccr_fs_divider #(
    .CNT_W(21)
  ) u_fs_divider (
    .clk(clk),
    .rst(rst),
    .divCode(divCodeQ),
    .frameSyncQ(frameSyncQ)
  );

  // adc input gain code
  always_ff @(posedge clk) begin
    if (rst) begin
      adcGainCodeQ <= `CCR_SIX_RST;
    end else if (wr5) begin
      adcGainCodeQ <= wrData_q[`CCR_SIX_HI:`CCR_SIX_LO];
    end
  end

  // gain in half-dB units, codes 31 and above mute
  always_ff @(posedge clk) begin
    if (rst) begin
      adcGainHalfDbQ <= 7'h00;
      adcInputMuteQ <= 1'b0;
    end else if (adcGainCodeQ <= `CCR_GAIN_LIN_MAX) begin
      adcGainHalfDbQ <= 7'(adcGainCodeQ) * `CCR_GAIN_STEP; // R13
      adcInputMuteQ <= 1'b0;
    end else if (adcGainCodeQ == `CCR_GAIN_C28) begin
      adcGainHalfDbQ <= `CCR_GAIN_42DB; // R14
      adcInputMuteQ <= 1'b0;
    end else if (adcGainCodeQ == `CCR_GAIN_C29) begin
      adcGainHalfDbQ <= `CCR_GAIN_48DB; // R14
      adcInputMuteQ <= 1'b0;
    end else if (adcGainCodeQ == `CCR_GAIN_C30) begin
      adcGainHalfDbQ <= `CCR_GAIN_54DB; // R14
      adcInputMuteQ <= 1'b0;
    end else begin
      adcGainHalfDbQ <= 7'h00;
      adcInputMuteQ <= 1'b1; // R14
    end
  end

endmodule

// File: verif/ccr_regs_checker.sv
// assertions on the codec control register outputs
`timescale 1ns/1ps
module ccr_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire ccr_pkg::ccr_drv_t driverCtrlQ,
  input wire logic [1:0] osrSelectQ,
  input wire logic [9:0] osrRatioQ,
  input wire logic [5:0] biasDacQ,
  input wire ccr_pkg::ccr_div_t divCodeQ,
  input wire logic frameSyncQ,
  input wire logic [5:0] adcGainCodeQ,
  input wire logic [6:0] adcGainHalfDbQ,
  input wire logic adcInputMuteQ
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  function automatic logic [6:0] halfDb(input logic [5:0] c);
    return (c <= 6'h1B) ? {1'b0, c} * 7'h03 : (c == 6'h1C) ? 7'h54 :
      (c == 6'h1D) ? 7'h60 : (c == 6'h1E) ? 7'h6C : 7'h00;
  endfunction
  osr_fast_a: assert property (osrSelectQ[0] |=> osrRatioQ == 10'h200)
    else $error("ratio not 512");
  osr_mid_a: assert property (osrSelectQ == 2'h2 |=> osrRatioQ == 10'h100)
    else $error("ratio not 256");
  osr_slow_a: assert property (osrSelectQ == 2'h0 |=> osrRatioQ == 10'h080)
    else $error("ratio not 128");
  gain_map_a: assert property (1'b1 |=> adcGainHalfDbQ == halfDb($past(adcGainCodeQ)))
    else $error("gain value wrong for code");
  gain_mute_a: assert property (1'b1 |=> adcInputMuteQ == ($past(adcGainCodeQ) >= 6'h1F))
    else $error("input mute wrong for code");
  frame_pulse_a: assert property (frameSyncQ |=> !frameSyncQ [*8])
    else $error("frame pulses too close");
  regs_quiet_a: assert property (!$past(rst) && !$stable({driverCtrlQ, osrSelectQ,
    biasDacQ, divCodeQ, adcGainCodeQ}) |-> !scl)
    else $error("register changed while clock high");
  div_m_only_a: assert property (!$past(rst) && $changed(divCodeQ.mCode)
    |-> $stable({divCodeQ.nCode, divCodeQ.pCode}))
    else $error("m write disturbed n or p");
  div_np_only_a: assert property (!$past(rst) && $changed({divCodeQ.nCode,
    divCodeQ.pCode}) |-> $stable(divCodeQ.mCode))
    else $error("n p write disturbed m");
endmodule
bind ccr_regs ccr_regs_checker u_chk (.clk, .rst, .scl, .driverCtrlQ, .osrSelectQ,
  .osrRatioQ, .biasDacQ, .divCodeQ, .frameSyncQ, .adcGainCodeQ, .adcGainHalfDbQ,
  .adcInputMuteQ);

// File: verif/ccr_host_model.sv
// two-wire host model for the control port
`timescale 1ns/1ps
module ccr_host_model (
  input wire logic clk,
  input wire logic sdaOeQ,
  input wire logic sdaOutQ,
  output logic scl,
  output logic sdaIn
);
  logic sdaDrv;
  int gap;
  // open-drain data line with pull-up
  assign sdaIn = sdaDrv & (sdaOeQ ? sdaOutQ : 1'b1);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
    gap = 7;
  end
  // clock moves first, data a few cycles later
  task automatic hold(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    repeat (3) @(posedge clk);
    sdaDrv <= d;
    repeat (gap) @(posedge clk);
  endtask
  task automatic start();
    hold(1'b0, 1'b1);
    hold(1'b1, 1'b1);
    hold(1'b1, 1'b0);
    hold(1'b0, 1'b0);
  endtask
  task automatic stop();
    hold(1'b0, 1'b0);
    hold(1'b1, 1'b0);
    hold(1'b1, 1'b1);
  endtask
  // eight bits plus acknowledge, msb first
  task automatic bit9(input logic [8:0] w, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      hold(1'b0, w[i]);
      hold(1'b1, w[i]);
      r[i] = sdaIn;
    end
  endtask
  task automatic access(input logic [6:0] a, input logic [7:0] pa, da, input logic rd,
    output logic ok, output logic [7:0] q);
    logic [8:0] r0, r1, r2;
    start();
    bit9({a, 1'b0, 1'b1}, r0);
    bit9({pa, 1'b1}, r1);
    if (rd) begin
      start();
      bit9({a, 1'b1, 1'b1}, r2);
      ok = ~r0[0] & ~r1[0] & ~r2[0];
      bit9(9'h1FF, r2);
    end else begin
      bit9({da, 1'b1}, r2);
      ok = ~r0[0] & ~r1[0] & ~r2[0];
    end
    q = r2[8:1];
    stop();
  endtask
endmodule

// File: verif/ccr_regs_tb_top.sv
// self-checking bench for the codec control register subset
`timescale 1ns/1ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module ccr_regs_tb_top;
  localparam logic [6:0] ADDR = 7'h40;
  // arbitrary version code
  localparam logic [2:0] VER = 3'h2;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, sdaIn, sdaOutQ, sdaOeQ, frameSyncQ, adcInputMuteQ, ok;
  ccr_pkg::ccr_drv_t driverCtrlQ;
  ccr_pkg::ccr_div_t divCodeQ;
  logic [1:0] osrSelectQ;
  logic [9:0] osrRatioQ;
  logic [5:0] biasDacQ, adcGainCodeQ, d;
  logic [6:0] adcGainHalfDbQ, mf;
  logic [3:0] nf;
  logic [2:0] pf;
  logic [7:0] q;
  logic [31:0] seed = 32'h0000002E;
  int errors = 0;
  int checksDone = 0;
  int cycles = 0;
  always #20 clk = ~clk;
  ccr_host_model u_ccr_host_model (.clk, .sdaOeQ, .sdaOutQ, .scl, .sdaIn);
  ccr_regs #(.DEV_ADDR(ADDR), .VERSION_CODE(VER)) u_ccr_regs (.clk, .rst, .scl, .sdaIn,
    .sdaOutQ, .sdaOeQ, .driverCtrlQ, .osrSelectQ, .osrRatioQ, .biasDacQ, .divCodeQ,
    .frameSyncQ, .adcGainCodeQ, .adcGainHalfDbQ, .adcInputMuteQ);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [6:0] half(input logic [5:0] c);
    return (c <= 6'h1B) ? {1'b0, c} * 7'h03 : (c == 6'h1C) ? 7'h54 :
      (c == 6'h1D) ? 7'h60 : (c == 6'h1E) ? 7'h6C : 7'h00;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] pa, da, input logic expAck);
    u_ccr_host_model.access(a, pa, da, 1'b0, ok, q);
    `CHK(ok, expAck)
  endtask
  task automatic rd(input logic [7:0] pa);
    u_ccr_host_model.access(ADDR, pa, 8'h00, 1'b1, ok, q);
    `CHK(ok, 1'b1)
  endtask
  // pulse to pulse distance of frame sync
  task automatic measure(input int expP);
    int n;
    n = 0;
    while (frameSyncQ !== 1'b1 && n < 5000) begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (frameSyncQ !== 1'b1 && n < 5000);
    `CHK(n, expP)
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      errors++;
      conclude();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(driverCtrlQ, 5'h00)
    `CHK(osrRatioQ, 10'h080)
    `CHK(biasDacQ, 6'h00)
    `CHK(adcGainHalfDbQ, 7'h00)
    `CHK(sdaOeQ, 1'b0)
    `CHK(sdaOutQ, 1'b0)
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      d = (i < 2) ? 6'h3F : seed[5:0];
      wr(ADDR, 8'h03, {i[0] ? 2'h3 : 2'h1, d}, 1'b1);
      if (i[0]) `CHK(biasDacQ, d)
      else `CHK(driverCtrlQ, {d[5], d[3:0]})
      rd(8'h03);
      `CHK(q, (i[0] ? {2'h3, d} : {2'h1, d[5], 1'b0, d[3:0]}))
    end
    for (int c = 0; c < 4; c++) begin
      wr(ADDR, 8'h03, {6'h20, c[1:0]}, 1'b1);
      `CHK(osrSelectQ, c[1:0])
      `CHK(osrRatioQ, c[0] ? 10'h200 : c[1] ? 10'h100 : 10'h080)
      rd(8'h03);
      `CHK(q[4:2], VER)
      `CHK(q, {2'h2, 1'b0, VER, c[1:0]})
    end
    for (int c = 0; c < 32; c++) begin
      wr(ADDR, 8'h05, {2'h0, c[5:0]}, 1'b1);
      `CHK(adcGainCodeQ, c[5:0])
      `CHK(adcGainHalfDbQ, half(c[5:0]))
      `CHK(adcInputMuteQ, c == 31)
    end
    rd(8'h05);
    `CHK(q, 8'h1F)
    for (int i = 0; i < 5; i++) begin
      seed = xs(seed);
      {mf, nf, pf} = (i == 0) ? {7'h02, 4'h1, 3'h3} : (i == 1) ? {7'h00, 4'h1, 3'h1} :
        (i == 2) ? {7'h01, 4'h0, 3'h0} :
        {5'h00, seed[1:0] | 2'h1, 2'h0, seed[3:2] | 2'h1, 1'b0, seed[5:4] | 2'h1};
      wr(ADDR, 8'h04, {1'b1, mf}, 1'b1);
      wr(ADDR, 8'h04, {1'b0, nf, pf}, 1'b1);
      `CHK(divCodeQ, {mf, nf, pf})
      rd(8'h04);
      `CHK(q, {1'b0, nf, pf})
      measure(16 * (mf == 0 ? 128 : mf) * (nf == 0 ? 16 : nf) *
        (pf == 0 ? 8 : pf));
    end
    u_ccr_host_model.gap = 15;
    wr(ADDR, 8'h03, 8'h40, 1'b1);
    wr(7'h41, 8'h05, 8'h05, 1'b0);
    wr(ADDR, 8'h05, 8'h45, 1'b1);
    wr(ADDR, 8'h06, 8'h00, 1'b1);
    wr(ADDR, 8'h03, 8'h3F, 1'b1);
    `CHK(adcGainCodeQ, 6'h1F)
    `CHK(driverCtrlQ, 5'h00)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(adcGainCodeQ, 6'h00)
    `CHK(biasDacQ, 6'h00)
    `CHK(osrSelectQ, 2'h0)
    `CHK(divCodeQ, {7'h01, 4'h1, 3'h1})
    measure(16);
    conclude();
  end
endmodule
